// *** logic/rcc_pkg.sv ***
// package: register map, field layout and constants for the rtc calendar block
package rcc_pkg;
  // register indices on the plain port
  localparam logic [1:0] ADDR_CFG  = 2'h0;  // rtc_config_calibration
  localparam logic [1:0] ADDR_WINL = 2'h1;  // value_window_low byte
  localparam logic [1:0] ADDR_WINH = 2'h2;  // value_window_high byte
  localparam logic [1:0] ADDR_WIN  = 2'h3;  // value_window full word
  // pointer codes
  localparam logic [1:0] PTR_MINUTES_SECONDS_PAIR = 2'h0;
  localparam logic [1:0] PTR_WDHR   = 2'h1;
  localparam logic [1:0] PTR_MTHDY  = 2'h2;
  localparam logic [1:0] PTR_YEAR   = 2'h3;
  // config field positions
  localparam int CFG_ON_BIT     = 15;
  localparam int CFG_UNLOCK_BIT = 13;
  localparam int CFG_SYNC_BIT   = 12;
  localparam int CFG_PTR_LO     = 8;
  // cal step: four pulses per code step
  localparam int CAL_SHIFT = 2;
  localparam logic [7:0] CAL_NONE = 8'h00;
  // bcd limits
  localparam logic [3:0] BCD_NINE  = 4'h9;
  localparam logic [3:0] BCD_ZERO  = 4'h0;
  localparam logic [3:0] BCD_ONE   = 4'h1;
  localparam logic [3:0] MTH_TWO   = 4'h2;
  localparam logic [1:0] DAY_THREE = 2'h3;
  localparam logic [1:0] DAY_TEN_Z = 2'h0;
  localparam logic [3:0] DAY_LAST1 = 4'h1;  // day 31 wraps to 01
  // minutes in one day, for the day boundary counter
  localparam logic [10:0] MIN_PER_DAY = 11'h5A0;
  // calendar value struct
  typedef struct packed {
    logic [3:0] year_tens_digit;
    logic [3:0] year_ones_digit;
    logic       month_tens_digit;
    logic [3:0] month_ones_digit;
    logic [1:0] day_tens_digit;
    logic [3:0] day_ones_digit;
  } rcc_cal_s;
  localparam rcc_cal_s CAL_RESET = '{4'h0, 4'h0, 1'b0, 4'h1, 2'h0, 4'h1};
endpackage : rcc_pkg

// *** logic/rcc_tick.sv ***
// minute pulse generator with drift calibration applied once per minute
`timescale 1ns/1ps
module rcc_tick #(
  parameter int unsigned PULSES_PER_MIN = 32'd1966080  // nominal rtc pulses per minute
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       run,
  input  wire logic [7:0] cal,
  // minute event
  output logic            minute_tick
);
  logic [31:0] cnt_q;  // pulses so far this minute
  logic [31:0] cnt_d;
  logic [31:0] limit;  // pulses forming this minute
  logic        tick_d;
  logic        tick_q;

  // length of minute from signed code, four pulses per step
  always_comb begin
    limit = PULSES_PER_MIN;
    if (cal != rcc_pkg::CAL_NONE) begin  // R1
      // sign extend then scale; positive adds, negative subtracts
      limit = PULSES_PER_MIN + 32'({{24{cal[7]}}, cal} << rcc_pkg::CAL_SHIFT);  // R2 R3
    end
  end

  // counter next state
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (run) begin
      if (cnt_q + 32'h0000_0001 >= limit) begin
        cnt_d  = 32'h0000_0000;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 32'h0000_0001;
      end
    end
  end

  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign minute_tick = tick_q;

  // zero code leaves minute length untouched
  cal_zero_a: assert property (@(posedge clk) disable iff (rst)  // R1
    (cal == rcc_pkg::CAL_NONE) |-> (limit == PULSES_PER_MIN))
    else $error("zero calibration changed minute length");
  // positive max adds 508
  cal_pos_a: assert property (@(posedge clk) disable iff (rst)  // R2
    (cal == 8'h7F) |-> (limit == PULSES_PER_MIN + 32'd508))
    else $error("max positive calibration wrong");
  // negative max subtracts 512
  cal_neg_a: assert property (@(posedge clk) disable iff (rst)  // R3
    (cal == 8'h80) |-> (limit == PULSES_PER_MIN - 32'd512))
    else $error("max negative calibration wrong");
endmodule : rcc_tick

// *** logic/rcc_top.sv ***
// rtc calendar registers: config/calibration, pointer window, year and month/day
// Behaviour
// R1 - zero code makes no minute adjustment
// R2 - positive codes add four pulses per step
// R3 - negative codes subtract four pulses per step
// R4 - config register reset only by power-on
// R5 - module enable written only when unlocked
// R6 - sync status cleared on minutes/seconds low write
// R7 - year holds two bcd digits, upper zero
// R8 - year writes only when unlocked
// R9 - month digits at 12 and 11-8, read-only
// R10 - day digits at 5-4 and 3-0 writable
// R11 - month/day writes only when unlocked
// R12 - unused month/day bits read zero
// R13 - pointer selects window register pair
// R14 - high byte write decrements pointer, stops 00
// R15 - window reads decrement pointer too
// R16 - calendar digits carry in bcd
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
module rcc_top #(
  parameter int unsigned PULSES_PER_MIN = 32'd1966080  // rtc pulses per minute
) (
  // clock and resets
  input  wire logic        clk,
  input  wire logic        rst,        // power-on reset
  input  wire logic        sys_rst,    // other reset sources, synchronous
  // register port
  input  wire logic [1:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // status out
  output logic             module_on,
  output logic             minute_tick
);
  // config fields
  logic       on_q, on_d;             // clock_module_on
  logic       unlock_q, unlock_d;     // time_write_unlock
  logic       sync_q, sync_d;         // read-only status
  logic [1:0] ptr_q, ptr_d;           // value_window_pointer
  logic [7:0] cal_q, cal_d;           // drift code
  // calendar state
  rcc_pkg::rcc_cal_s date_q, date_d;
  // read path
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] win_val;
  logic        win_acc_wr;            // word or low or high write
  logic        win_rd;
  logic        hi_wr;
  logic [10:0] min_cnt_q, min_cnt_d;  // minutes into the current day
  logic        day_roll_req;          // last minute of the day

  // window access decode
  assign win_rd     = rd && (addr != rcc_pkg::ADDR_CFG);
  assign win_acc_wr = wr && (addr != rcc_pkg::ADDR_CFG);
  assign hi_wr      = wr && (addr == rcc_pkg::ADDR_WINH || addr == rcc_pkg::ADDR_WIN);

  // pointer step down, saturating at zero
  function automatic logic [1:0] ptr_dec(input logic [1:0] p);
    ptr_dec = (p == rcc_pkg::PTR_MINUTES_SECONDS_PAIR) ? rcc_pkg::PTR_MINUTES_SECONDS_PAIR : p - 2'h1;
  endfunction : ptr_dec

  // bcd digit increment with wrap
  function automatic logic [3:0] bcd_inc(input logic [3:0] d);
    bcd_inc = (d >= rcc_pkg::BCD_NINE) ? rcc_pkg::BCD_ZERO : d + 4'h1;
  endfunction : bcd_inc

  // minute source
  rcc_tick #(
    .PULSES_PER_MIN(PULSES_PER_MIN)
  ) u_tick (
    .clk        (clk),
    .rst        (rst),
    .run        (on_q),
    .cal        (cal_q),
    .minute_tick(minute_tick)
  );

  // window contents for current pointer
  always_comb begin
    case (ptr_q)  // R13
      rcc_pkg::PTR_YEAR:
        win_val = {8'h00, date_q.year_tens_digit, date_q.year_ones_digit};  // R7
      rcc_pkg::PTR_MTHDY:
        win_val = {3'b000, date_q.month_tens_digit, date_q.month_ones_digit,  // R9
                   2'b00, date_q.day_tens_digit, date_q.day_ones_digit};  // R10 R12
      default:
        win_val = 16'h0000;  // time counters live elsewhere
    endcase
  end

  // config next state
  always_comb begin
    on_d     = on_q;
    unlock_d = unlock_q;
    sync_d   = sync_q;
    ptr_d    = ptr_q;
    cal_d    = cal_q;
    if (wr && addr == rcc_pkg::ADDR_CFG) begin
      unlock_d = wdata[rcc_pkg::CFG_UNLOCK_BIT];
      ptr_d    = wdata[rcc_pkg::CFG_PTR_LO +: 2];
      cal_d    = wdata[7:0];
      if (unlock_q) begin
        on_d = wdata[rcc_pkg::CFG_ON_BIT];  // R5
      end
    end else if (hi_wr || win_rd) begin
      ptr_d = ptr_dec(ptr_q);  // R14 R15
    end
    // minute event sets status; it beats a same-cycle clear so no event is lost
    if (minute_tick) begin
      sync_d = 1'b1;
    end else if (win_acc_wr && addr != rcc_pkg::ADDR_WINH && ptr_q == rcc_pkg::PTR_MINUTES_SECONDS_PAIR
                 && unlock_q) begin
      sync_d = 1'b0;  // R6
    end
  end

  // config register: only power-on reset clears it, sys_rst ignored on purpose
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin  // R4
      on_q     <= 1'b0;
      unlock_q <= 1'b0;
      sync_q   <= 1'b0;
      ptr_q    <= rcc_pkg::PTR_MINUTES_SECONDS_PAIR;
      cal_q    <= rcc_pkg::CAL_NONE;
    end else begin
      on_q     <= on_d;
      unlock_q <= unlock_d;
      sync_q   <= sync_d;
      ptr_q    <= ptr_d;
      cal_q    <= cal_d;
    end
  end

  // calendar next state: software write beats advance in same cycle
  always_comb begin
    date_d = date_q;
    if (win_acc_wr && unlock_q && ptr_q == rcc_pkg::PTR_YEAR
        && addr != rcc_pkg::ADDR_WINH) begin
      date_d.year_tens_digit = wdata[7:4];  // R8
      date_d.year_ones_digit = wdata[3:0];
    end else if (win_acc_wr && unlock_q && ptr_q == rcc_pkg::PTR_MTHDY
                 && addr != rcc_pkg::ADDR_WINH) begin
      // month bits ignored: read-only
      date_d.day_tens_digit = wdata[5:4];  // R11
      date_d.day_ones_digit = wdata[3:0];
    end else if (minute_tick && sys_rst == 1'b0 && day_roll_req) begin
      // simplified: a day boundary strobe advances the date
      date_d.day_ones_digit = bcd_inc(date_q.day_ones_digit);  // R16
      if (date_q.day_ones_digit == rcc_pkg::BCD_NINE) begin
        date_d.day_tens_digit = date_q.day_tens_digit + 2'h1;
      end
      if (date_q.day_tens_digit == rcc_pkg::DAY_THREE
          && date_q.day_ones_digit == rcc_pkg::DAY_LAST1) begin
        date_d.day_tens_digit   = rcc_pkg::DAY_TEN_Z;
        date_d.day_ones_digit   = rcc_pkg::BCD_ONE;
        date_d.month_ones_digit = bcd_inc(date_q.month_ones_digit);
        if (date_q.month_ones_digit == rcc_pkg::BCD_NINE) begin
          date_d.month_tens_digit = 1'b1;
        end
        if (date_q.month_tens_digit && date_q.month_ones_digit == rcc_pkg::MTH_TWO) begin
          date_d.month_tens_digit = 1'b0;
          date_d.month_ones_digit = rcc_pkg::BCD_ONE;
          date_d.year_ones_digit  = bcd_inc(date_q.year_ones_digit);
          if (date_q.year_ones_digit == rcc_pkg::BCD_NINE) begin
            date_d.year_tens_digit = bcd_inc(date_q.year_tens_digit);
          end
        end
      end
    end
  end

  // day boundary request: counted minutes per day
  assign day_roll_req = (min_cnt_q == rcc_pkg::MIN_PER_DAY - 11'h001);
  always_comb begin
    min_cnt_d = min_cnt_q;
    if (minute_tick) begin
      min_cnt_d = day_roll_req ? 11'd0 : min_cnt_q + 11'd1;
    end
  end

  // calendar registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      date_q    <= rcc_pkg::CAL_RESET;
      min_cnt_q <= 11'd0;
    end else begin
      date_q    <= date_d;
      min_cnt_q <= min_cnt_d;
    end
  end

  // read data, valid one cycle after strobe only
  always_comb begin
    rdata_d = 16'h0000;
    if (rd) begin
      if (addr == rcc_pkg::ADDR_CFG) begin
        rdata_d = {on_q, 1'b0, unlock_q, sync_q, 2'b00, ptr_q, cal_q};
      end else begin
        rdata_d = win_val;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata     = rdata_q;
  assign module_on = on_q;

  // locked write leaves enable alone
  on_lock_a: assert property (@(posedge clk) disable iff (rst)  // R5
    (wr && addr == rcc_pkg::ADDR_CFG && !unlock_q) |=> (on_q == $past(on_q)))
    else $error("enable changed while locked");
  // pointer stops at zero on reads
  ptr_sat_a: assert property (@(posedge clk) disable iff (rst)  // R14
    (win_rd && ptr_q == rcc_pkg::PTR_MINUTES_SECONDS_PAIR) |=> (ptr_q == rcc_pkg::PTR_MINUTES_SECONDS_PAIR))
    else $error("pointer wrapped below zero");
  // window read decrements
  ptr_rd_a: assert property (@(posedge clk) disable iff (rst)  // R15
    (win_rd && ptr_q != rcc_pkg::PTR_MINUTES_SECONDS_PAIR) |=> (ptr_q == $past(ptr_q) - 2'h1))
    else $error("pointer not decremented on read");
  // year locked write ignored
  year_lock_a: assert property (@(posedge clk) disable iff (rst)  // R8
    (wr && addr == rcc_pkg::ADDR_WINL && ptr_q == rcc_pkg::PTR_YEAR && !unlock_q
     && !minute_tick)
    |=> (date_q.year_ones_digit == $past(date_q.year_ones_digit)))
    else $error("year written while locked");
  // month/day read pads zero
  mthdy_pad_a: assert property (@(posedge clk) disable iff (rst)  // R12
    (rd && addr == rcc_pkg::ADDR_WIN && ptr_q == rcc_pkg::PTR_MTHDY)
    |=> (rdata[15:13] == 3'b000 && rdata[7:6] == 2'b00))
    else $error("unused month/day bits not zero");
  // year upper byte reads zero
  year_pad_a: assert property (@(posedge clk) disable iff (rst)  // R7
    (rd && addr == rcc_pkg::ADDR_WIN && ptr_q == rcc_pkg::PTR_YEAR) |=> (rdata[15:8] == 8'h00))
    else $error("year upper byte not zero");
  // day digits stay bcd
  day_bcd_a: assert property (@(posedge clk) disable iff (rst)  // R16
    (date_q.day_ones_digit <= rcc_pkg::BCD_NINE) |=> (date_q.day_ones_digit <= rcc_pkg::BCD_NINE))
    else $error("day digit left bcd range");
  // status cleared by minutes_seconds_pair low write
  sync_clr_a: assert property (@(posedge clk) disable iff (rst)  // R6
    (wr && addr == rcc_pkg::ADDR_WINL && ptr_q == rcc_pkg::PTR_MINUTES_SECONDS_PAIR && unlock_q
     && !minute_tick) |=> !sync_q)
    else $error("status not cleared");
endmodule : rcc_top

// *** tb/rcc_top_bench.sv ***
// self-checking bench for the rtc calendar register block
`timescale 1ns/1ps
module rcc_top_bench;
  localparam int unsigned PPM = 2000;  // short minute keeps the run small
  // clock, resets and register port
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sys_rst = 1'b0;
  logic [1:0]  addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        module_on;
  logic        minute_tick;
  int          mismatches = 0;   // failed comparisons
  int          checks_done = 0;  // all comparisons
  int          cycles = 0;       // hang guard
  logic [15:0] v;                // last read word

  rcc_top #(.PULSES_PER_MIN(PPM)) i_dut (
    .clk(clk), .rst(rst), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .module_on(module_on), .minute_tick(minute_tick)
  );

  // free running 100 MHz clock
  always #5 clk = ~clk;

  // cut a hang short well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end

  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one-cycle write strobe
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;  // let the write settle before the caller looks at outputs
  endtask : reg_wr

  // one-cycle read strobe, data taken in the following cycle only
  task automatic reg_rd(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_rd

  // cycles until the next minute pulse, bounded
  task automatic tick_gap(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n = n + 1;
    end while (minute_tick !== 1'b1 && n < 4000);
  endtask : tick_gap

  // enable refused while locked, year write refused while locked
  task automatic t_lock;
    reg_wr(rcc_pkg::ADDR_CFG, 16'h8300);  // on plus pointer to year, still locked
    check("module_on locked", {15'h0000, module_on}, 16'h0000);
    reg_wr(rcc_pkg::ADDR_WINL, 16'h0042);
    reg_rd(rcc_pkg::ADDR_WIN);
    check("year locked", v, 16'h0000);
    reg_rd(rcc_pkg::ADDR_WIN);
    check("month day reset", v, 16'h0101);
  endtask : t_lock

  // year write, then reads walk the pointer down and stop at 00
  task automatic t_year_walk;
    reg_wr(rcc_pkg::ADDR_CFG, 16'h2300);
    reg_wr(rcc_pkg::ADDR_WINL, 16'hFF25);  // upper byte must not stick
    reg_rd(rcc_pkg::ADDR_WIN);
    check("year value", v, 16'h0025);
    reg_rd(rcc_pkg::ADDR_CFG);
    check("ptr after read", {14'h0000, v[9:8]}, 16'h0002);
    reg_rd(rcc_pkg::ADDR_WINH);  // byte read decrements as well
    check("month day via high", v, 16'h0101);
    reg_rd(rcc_pkg::ADDR_WINL);
    reg_rd(rcc_pkg::ADDR_CFG);
    check("ptr at floor", {14'h0000, v[9:8]}, 16'h0000);
  endtask : t_year_walk

  // month/day: day writable, month read-only, loose bits zero, lock honoured
  task automatic t_month_day;
    reg_wr(rcc_pkg::ADDR_CFG, 16'h2200);
    reg_wr(rcc_pkg::ADDR_WINL, 16'hFFF1);  // bits 7-6 and month bits ignored
    reg_rd(rcc_pkg::ADDR_CFG);
    check("ptr kept by low write", {14'h0000, v[9:8]}, 16'h0002);
    reg_wr(rcc_pkg::ADDR_CFG, 16'h0200);  // relock, keep pointer
    reg_wr(rcc_pkg::ADDR_WINL, 16'h0012);
    reg_rd(rcc_pkg::ADDR_WIN);
    check("month day value", v, 16'h0131);
  endtask : t_month_day

  // high byte writes step the pointer down and hold at 00
  task automatic t_high_write;
    reg_wr(rcc_pkg::ADDR_CFG, 16'h2300);
    reg_wr(rcc_pkg::ADDR_WINH, 16'h0000);
    reg_rd(rcc_pkg::ADDR_CFG);
    check("ptr one step", {14'h0000, v[9:8]}, 16'h0002);
    repeat (3) reg_wr(rcc_pkg::ADDR_WINH, 16'h0000);
    reg_rd(rcc_pkg::ADDR_CFG);
    check("ptr held at 00", {14'h0000, v[9:8]}, 16'h0000);
    reg_rd(rcc_pkg::ADDR_WIN);  // read at 00 must not wrap
    reg_rd(rcc_pkg::ADDR_CFG);
    check("ptr read at 00", {14'h0000, v[9:8]}, 16'h0000);
    reg_wr(rcc_pkg::ADDR_CFG, 16'h2300);  // back to year; high byte write left it alone
    reg_rd(rcc_pkg::ADDR_WIN);
    check("year kept", v, 16'h0025);
  endtask : t_high_write

  // minute length per calibration code, then sync clear and reset scope
  task automatic t_cal;
    logic [7:0] codes [5];
    int         n;
    int         exp;
    codes = '{8'h00, 8'h01, 8'h7F, 8'hFF, 8'h80};
    reg_wr(rcc_pkg::ADDR_CFG, 16'h2000);  // unlock first, then turn on
    for (int i = 0; i < 5; i++) begin
      reg_wr(rcc_pkg::ADDR_CFG, {8'hA0, codes[i]});
      tick_gap(n);
      tick_gap(n);  // first full minute with the new code
      tick_gap(n);
      exp = int'(PPM) + 4 * int'(signed'(codes[i]));
      check("minute length", 16'(n), 16'(exp));
    end
    check("module_on", {15'h0000, module_on}, 16'h0001);
    reg_rd(rcc_pkg::ADDR_CFG);
    check("sync set", {15'h0000, v[12]}, 16'h0001);
    reg_wr(rcc_pkg::ADDR_WINL, 16'h0000);  // pointer 00: seconds byte
    reg_rd(rcc_pkg::ADDR_CFG);
    check("sync cleared", {15'h0000, v[12]}, 16'h0000);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    reg_rd(rcc_pkg::ADDR_CFG);
    check("cfg after sys reset", v & 16'hEFFF, 16'hA080);
    check("on after sys reset", {15'h0000, module_on}, 16'h0001);
  endtask : t_cal

  // verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("module_on reset", {15'h0000, module_on}, 16'h0000);
    check("tick reset", {15'h0000, minute_tick}, 16'h0000);
    t_lock();
    t_year_walk();
    t_month_day();
    t_high_write();
    t_cal();
    final_report();
  end
endmodule : rcc_top_bench
